// [core/boot_reset_security_ctrl.sv]
// Boot, reset and code protection control with Wishbone register access
//
// What this block does
// - Bits 7, 1 and 0 all set trigger a full chip reset once the soft timer reads zero.
// - Bit 5 reads one while running loader bank, else zero.
// - Bit 4 enables auxiliary RAM when one.
// - Control register writable only after keys 87h then 59h.
// - Any other key value closes control register write access.
// - Value 83h, timer expiry in idle resets to application bank.
// - After a chip reset, execution starts in application bank.
// - Reboot to loader bank when P2.7 and P2.6 low, or P4.3 low.
// - Security bits once cleared return high only by erase-all or i_rst_n.
// - Security register only reachable in programming mode, at Wishbone C4h.
// - Lock bit zero refuses code and security register access.
// - Restriction zero: external code reads see external memory only.
// - Code reads from internal memory always reach both spaces.
// - Restriction one: code reads are never limited.
// - Encryption enabled: port 0 output data is encoded.
// - Encryption enable cleared only by whole-chip erase or i_rst_n.
// - Security bit 7 zero halves oscillator amplifier gain.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module boot_reset_security_ctrl
  import boot_sec_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_p2_7,
  input  wire logic        i_p2_6,
  input  wire logic        i_p4_3,
  input  wire logic        i_cpu_idle,
  input  wire logic        i_fetch_external,
  input  wire logic        i_code_read_internal,
  input  wire logic        i_erase_all,
  input  wire logic [7:0]  i_p0_data,
  output logic             o_chip_reset,
  output logic             o_loader_running_flag,
  output logic             o_aux_ram_enable,
  output logic             o_code_access_allow,
  output logic             o_code_read_internal_ok,
  output logic [7:0]       o_p0_data,
  output logic             o_osc_half_gain
);
  logic [7:0] cpc_reg, cpc_next;
  logic [7:0] sec_reg, sec_next;
  logic [7:0] timer_reg, timer_next;
  logic       loader_reg, loader_next;
  logic       booted_reg, booted_next;
  logic [1:0] boot_cnt_reg, boot_cnt_next;
  logic       gain_reg, gain_next;
  logic [3:0] rst_cnt_reg, rst_cnt_next;
  logic       rst_out_reg, rst_out_next;
  logic       ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic       lim_reg, lim_next;
  logic [7:0] p0_reg, p0_next;
  key_state_t key_reg, key_next;
  logic       strap;
  logic       wr, rd_ok, prog_mode, soft_go, chip_go;
  logic [7:0] wbyte, cpc_view;

  boot_strap_sync u_strap (
    .i_clock        (i_clock),
    .i_rst_n        (i_rst_n),
    .i_p2_7         (i_p2_7),
    .i_p2_6         (i_p2_6),
    .i_p4_3         (i_p4_3),
    .o_reboot_strap (strap)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a[7:2] == b[7:2]);
  endfunction

  always_comb
  begin
    wr        = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_reg & i_wb_sel[0];
    rd_ok     = i_wb_cyc & i_wb_stb & ~ack_reg;
    wbyte     = i_wb_dat[7:0];
    prog_mode = cpc_reg[BIT_PROGRAMMING_ENABLE];
    cpc_view  = (cpc_reg & (CPC_WRITE_MASK | 8'h08))
              | ({7'h0, loader_reg} << BIT_LOADER_RUNNING_FLAG);
    ack_next  = rd_ok;
    dat_next  = 32'h0;
    if (hit(i_wb_adr, ADDR_CHIP_PROGRAM_CONTROL))
      dat_next = {24'h0, cpc_view};
    else if (hit(i_wb_adr, ADDR_PROGRAM_UNLOCK_KEY))
      dat_next = {29'h0, key_reg};
    // security visible only in programming mode
    // lock zero hides the security register
    else if (hit(i_wb_adr, ADDR_SECURITY) && prog_mode
             && sec_reg[BIT_SEC_LOCK])
      dat_next = {24'h0, sec_reg};
    else if (hit(i_wb_adr, ADDR_BOOT_STATUS))
      dat_next = {31'h0, loader_reg};
    else if (hit(i_wb_adr, ADDR_SOFT_TIMER))
      dat_next = {24'h0, timer_reg};
  end

  always_comb
  begin
    key_next = key_reg;
    cpc_next = cpc_reg;
    sec_next = sec_reg;
    timer_next = timer_reg;
    if (wr && hit(i_wb_adr, ADDR_PROGRAM_UNLOCK_KEY))
    begin
      case (key_reg)
        KEY_LOCKED: key_next = (wbyte == UNLOCK_KEY_FIRST) ? KEY_HALF
                                                           : KEY_LOCKED;
        KEY_HALF:   key_next = (wbyte == UNLOCK_KEY_SECOND) ? KEY_OPEN
                             : (wbyte == UNLOCK_KEY_FIRST) ? KEY_HALF
                                                           : KEY_LOCKED;
        KEY_OPEN:   key_next = (wbyte == UNLOCK_KEY_FIRST) ? KEY_HALF
                             : (wbyte == UNLOCK_KEY_SECOND) ? KEY_OPEN
                                                            : KEY_LOCKED;
        default:    key_next = KEY_LOCKED;
      endcase
    end
    if (wr && hit(i_wb_adr, ADDR_CHIP_PROGRAM_CONTROL) && key_reg == KEY_OPEN)
      cpc_next = (wbyte & CPC_WRITE_MASK) | CPC_RESET_VALUE;
    // bits only programmed high to low
    if (wr && hit(i_wb_adr, ADDR_SECURITY) && prog_mode
        && sec_reg[BIT_SEC_LOCK])
      sec_next = sec_reg & wbyte;
    if (i_erase_all)
      sec_next = SEC_ERASED_VALUE;
    if (wr && hit(i_wb_adr, ADDR_SOFT_TIMER))
      timer_next = wbyte;
    else if (i_cpu_idle && timer_reg != 8'h00)
      timer_next = timer_reg - 8'h01;
  end

  always_comb
  begin
    // three bits set force a chip reset
    // An armed timer defers the reset to its expiry in idle
    chip_go = cpc_reg[BIT_SOFT_RESET_REQUEST] & cpc_reg[BIT_BOOT_BANK_SELECT]
            & cpc_reg[BIT_PROGRAMMING_ENABLE] & (timer_reg == 8'h00);
    // timed reset from idle when armed with 83h
    soft_go = ((cpc_reg & CPC_WRITE_MASK) == SOFT_RESET_VALUE) & i_cpu_idle
            & (timer_reg == 8'h01);
    rst_cnt_next = rst_cnt_reg;
    rst_out_next = 1'b0;
    loader_next  = loader_reg;
    // Straps need three edges through sync flops before use
    booted_next  = booted_reg | (boot_cnt_reg == 2'h3);
    boot_cnt_next = (boot_cnt_reg == 2'h3) ? boot_cnt_reg
                                           : boot_cnt_reg + 2'h1;
    gain_next    = ~sec_reg[BIT_SEC_OSC_GAIN];
    // strap selects loader bank once at start
    if (!booted_reg)
      loader_next = strap;
    // Start once only; the trigger bits stay set during the pulse
    if ((chip_go || soft_go) && rst_cnt_reg == 4'h0 && !rst_out_reg)
    begin
      rst_cnt_next = 4'(CHIP_RESET_CYCLES);
      loader_next  = 1'b0;
    end
    else if (rst_cnt_reg != 4'h0)
    begin
      rst_cnt_next = rst_cnt_reg - 4'h1;
      rst_out_next = 1'b1;
    end
    // external fetch may not read internal code while read limit bit is zero
    lim_next = i_code_read_internal & (~i_fetch_external
             | sec_reg[BIT_SEC_READ_LIMIT]);
    // port 0 data encoded when enabled
    p0_next = sec_reg[BIT_SEC_ENCRYPT] ? i_p0_data
                                       : (i_p0_data ^ ENCRYPT_KEY);
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      key_reg     <= KEY_LOCKED;
      cpc_reg     <= CPC_RESET_VALUE;
      sec_reg     <= SEC_ERASED_VALUE;
      timer_reg   <= TIMER_RESET_VALUE;
      loader_reg  <= 1'b0;
      booted_reg  <= 1'b0;
      boot_cnt_reg <= 2'h0;
      gain_reg    <= 1'b0;
      rst_cnt_reg <= 4'h0;
      rst_out_reg <= 1'b0;
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h0;
      lim_reg     <= 1'b0;
      p0_reg      <= 8'h00;
    end
    else if (rst_out_reg && rst_cnt_next == 4'h0)
    begin
      // Chip reset ends: control returns to power-on state, keeps security
      key_reg     <= KEY_LOCKED;
      cpc_reg     <= CPC_RESET_VALUE;
      timer_reg   <= TIMER_RESET_VALUE;
      sec_reg     <= sec_next;
      loader_reg  <= loader_next;
      booted_reg  <= booted_next;
      boot_cnt_reg <= boot_cnt_next;
      gain_reg    <= gain_next;
      rst_cnt_reg <= rst_cnt_next;
      rst_out_reg <= rst_out_next;
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
      lim_reg     <= lim_next;
      p0_reg      <= p0_next;
    end
    else
    begin
      key_reg     <= key_next;
      cpc_reg     <= cpc_next;
      sec_reg     <= sec_next;
      timer_reg   <= timer_next;
      loader_reg  <= loader_next;
      booted_reg  <= booted_next;
      boot_cnt_reg <= boot_cnt_next;
      gain_reg    <= gain_next;
      rst_cnt_reg <= rst_cnt_next;
      rst_out_reg <= rst_out_next;
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
      lim_reg     <= lim_next;
      p0_reg      <= p0_next;
    end
  end

  assign o_wb_ack                = ack_reg;
  assign o_wb_dat                = dat_reg;
  assign o_chip_reset            = rst_out_reg;
  assign o_loader_running_flag   = loader_reg;
  assign o_aux_ram_enable        = cpc_reg[BIT_AUX_RAM_ENABLE];
  assign o_code_access_allow     = sec_reg[BIT_SEC_LOCK];
  assign o_code_read_internal_ok = lim_reg;
  assign o_p0_data               = p0_reg;
  assign o_osc_half_gain         = gain_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  chk_chip_reset_pulse: assert property (
    chip_go && rst_cnt_reg == 4'h0 && !rst_out_reg
    |=> ##1 rst_out_reg [*5])
    else $error("Chip reset not held five cycles");
  chk_locked_no_write: assert property (
    wr && hit(i_wb_adr, ADDR_CHIP_PROGRAM_CONTROL) && key_reg != KEY_OPEN
    && !rst_out_reg |=> $stable(cpc_reg))
    else $error("Control written while locked");
  chk_bad_key_close: assert property (
    wr && hit(i_wb_adr, ADDR_PROGRAM_UNLOCK_KEY) && wbyte != UNLOCK_KEY_FIRST
    && wbyte != UNLOCK_KEY_SECOND |=> key_reg == KEY_LOCKED)
    else $error("Wrong key left writes open");
  chk_soft_reset_app: assert property (
    soft_go && rst_cnt_reg == 4'h0 && !rst_out_reg
    |=> !loader_reg ##1 rst_out_reg)
    else $error("Timed reset did not return to application bank");
  chk_sec_monotonic: assert property (
    !i_erase_all && !$past(i_erase_all) |-> (sec_reg & ~$past(sec_reg)) == 8'h0)
    else $error("Security bit rose without erase");
  chk_reserved_zero: assert property (
    (cpc_view & 8'h44 & ~8'h20) == 8'h0)
    else $error("Reserved control bit read as one");
  chk_aux_ram_bit: assert property (
    wr && hit(i_wb_adr, ADDR_CHIP_PROGRAM_CONTROL) && key_reg == KEY_OPEN
    && !rst_out_reg
    |=> o_aux_ram_enable == $past(wbyte[BIT_AUX_RAM_ENABLE]))
    else $error("Aux RAM enable mismatch");
  chk_gain_halved: assert property (
    !sec_reg[BIT_SEC_OSC_GAIN] |=> o_osc_half_gain)
    else $error("Gain not halved");
  chk_read_limit: assert property (
    i_fetch_external && !sec_reg[BIT_SEC_READ_LIMIT] |=> !lim_reg)
    else $error("External code read reached internal code");

  cov_unlock: cover property (key_reg == KEY_HALF ##1 key_reg == KEY_OPEN);
  cov_chip_reset: cover property (chip_go);
  cov_soft_reset: cover property (soft_go);
  cov_reboot: cover property (loader_reg);
endmodule // boot_reset_security_ctrl
`default_nettype wire

// [pkg/boot_sec_pkg.sv]
// Package: register map, field positions, keys and timing for boot control
package boot_sec_pkg;
  // Wishbone byte addresses (word aligned except control at BFh)
  localparam logic [7:0] ADDR_CHIP_PROGRAM_CONTROL = 8'hbf;
  localparam logic [7:0] ADDR_PROGRAM_UNLOCK_KEY   = 8'hc0;
  localparam logic [7:0] ADDR_SECURITY             = 8'hc4;
  localparam logic [7:0] ADDR_BOOT_STATUS          = 8'hc8;
  localparam logic [7:0] ADDR_SOFT_TIMER           = 8'hcc;
  localparam logic [7:0] ADDR_CPU_STATE            = 8'hd0;
  localparam logic [7:0] ADDR_MASK                 = 8'hfc;
  // chip_program_control fields
  localparam int BIT_SOFT_RESET_REQUEST  = 7;
  localparam int BIT_LOADER_RUNNING_FLAG = 5;
  localparam int BIT_AUX_RAM_ENABLE      = 4;
  localparam int BIT_MUST_BE_ONE         = 3;
  localparam int BIT_BOOT_BANK_SELECT    = 1;
  localparam int BIT_PROGRAMMING_ENABLE  = 0;
  localparam logic [7:0] CPC_WRITE_MASK  = 8'h93;
  localparam logic [7:0] CPC_RESET_VALUE = 8'h08;
  localparam logic [7:0] SOFT_RESET_VALUE = 8'h83;
  // Unlock keys
  localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h87;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h59;
  // Security register fields, all erased high
  localparam int BIT_SEC_LOCK        = 0;
  localparam int BIT_SEC_READ_LIMIT  = 1;
  localparam int BIT_SEC_ENCRYPT     = 2;
  localparam int BIT_SEC_OSC_GAIN    = 7;
  localparam logic [7:0] SEC_ERASED_VALUE = 8'hff;
  localparam logic [7:0] SECURITY_CODE_ADDR_HI = 8'hff;
  localparam logic [7:0] SECURITY_CODE_ADDR_LO = 8'hff;
  localparam logic [7:0] ENCRYPT_KEY = 8'h5a;
  // Chip reset pulse length
  localparam int CHIP_RESET_NS     = 200;
  localparam int CLOCK_PERIOD_NS   = 40;
  localparam int CHIP_RESET_CYCLES =
    (CHIP_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] TIMER_RESET_VALUE = 8'h00;
  // Key sequencer states
  typedef enum logic [2:0] {
    KEY_LOCKED = 3'b001,
    KEY_HALF   = 3'b010,
    KEY_OPEN   = 3'b100
  } key_state_t;
endpackage : boot_sec_pkg

// [core/boot_strap_sync.sv]
// Two-flop synchroniser and reboot strap decode for port pins
`timescale 1ns/1ns
`default_nettype none
module boot_strap_sync
  import boot_sec_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_p2_7,
  input  wire logic i_p2_6,
  input  wire logic i_p4_3,
  output logic      o_reboot_strap
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic       strap_reg;
  logic       strap_next;

  always_comb
  begin
    strap_next = (~sync_reg[2] & ~sync_reg[1]) | ~sync_reg[0];
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg  <= 3'h7;
      sync_reg  <= 3'h7;
      strap_reg <= 1'b0;
    end
    else
    begin
      meta_reg  <= {i_p2_7, i_p2_6, i_p4_3};
      sync_reg  <= meta_reg;
      strap_reg <= strap_next;
    end
  end

  assign o_reboot_strap = strap_reg;
endmodule // boot_strap_sync
`default_nettype wire

// [dv/boot_reset_security_ctrl_tb_top.sv]
// Self-checking bench for boot, reset and code protection control
`timescale 1ns/1ns
`default_nettype none
module boot_reset_security_ctrl_tb_top
  import boot_sec_pkg::*;
;
  typedef struct packed {logic p4; logic p27; logic p26; logic ldr;} row_t;
  logic        i_clock, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0]  i_wb_adr, i_p0_data, o_p0_data;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic        o_wb_ack, i_p2_7, i_p2_6, i_p4_3, i_cpu_idle;
  logic        i_fetch_external, i_code_read_internal, i_erase_all;
  logic        o_chip_reset, o_loader_running_flag, o_aux_ram_enable;
  logic        o_code_access_allow, o_code_read_internal_ok;
  logic        o_osc_half_gain;
  int          miscompares, check_count, n;
  row_t        rows [4];

  boot_reset_security_ctrl dut
  (
    .i_clock, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_p2_7, .i_p2_6,
    .i_p4_3, .i_cpu_idle, .i_fetch_external, .i_code_read_internal,
    .i_erase_all, .i_p0_data, .o_chip_reset, .o_loader_running_flag,
    .o_aux_ram_enable, .o_code_access_allow, .o_code_read_internal_ok,
    .o_p0_data, .o_osc_half_gain
  );

  initial
  begin
    i_clock = 1'h0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic cycle: hold request until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] d);
    int k;
    @(posedge i_clock);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_dat <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge i_clock);
      k++;
    end while (o_wb_ack !== 1'h1 && k < 20);
    chk("ack", {31'h0, o_wb_ack}, 32'h1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    i_wb_we  <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'h0, adr, 8'h00);
    chk("read data", rd, {24'h0, exp});
  endtask

  task automatic unlock();
    wb(1'h1, ADDR_PROGRAM_UNLOCK_KEY, UNLOCK_KEY_FIRST);
    wb(1'h1, ADDR_PROGRAM_UNLOCK_KEY, UNLOCK_KEY_SECOND);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge i_clock);
  endtask

  // Straps pass two sync flops, so allow several edges after release
  task automatic do_reset();
    @(posedge i_clock);
    i_rst_n <= 1'h0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'h1;
    settle(8);
  endtask

  // Waits for the chip reset pulse, then counts its width
  task automatic pulse_width(output int w);
    int k;
    k = 0;
    w = 0;
    while (o_chip_reset !== 1'h1 && k < 40)
    begin
      @(posedge i_clock);
      k++;
    end
    while (o_chip_reset === 1'h1 && w < 40)
    begin
      @(posedge i_clock);
      w++;
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    {i_wb_cyc, i_wb_stb, i_wb_we, i_cpu_idle, i_erase_all} = 5'h0;
    {i_fetch_external, i_code_read_internal} = 2'h0;
    {i_p2_7, i_p2_6, i_p4_3, i_rst_n} = 4'h0;
    i_wb_adr = 8'h00;
    i_wb_sel = 4'hf;
    i_wb_dat = 32'h0;
    i_p0_data = 8'h3c;
    rows = '{'{1'h1, 1'h1, 1'h1, 1'h0}, '{1'h1, 1'h0, 1'h0, 1'h1},
             '{1'h1, 1'h0, 1'h1, 1'h0}, '{1'h0, 1'h1, 1'h1, 1'h1}};
    settle(3);
    chk("ack in reset", {31'h0, o_wb_ack}, 32'h0);
    chk("access in reset", {31'h0, o_code_access_allow}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      {i_p4_3, i_p2_7, i_p2_6} <= {rows[i].p4, rows[i].p27, rows[i].p26};
      do_reset();
      chk("loader flag", {31'h0, o_loader_running_flag}, {31'h0, rows[i].ldr});
      rdchk(ADDR_CHIP_PROGRAM_CONTROL, {2'h0, rows[i].ldr, 5'h08});
    end
    wb(1'h1, ADDR_CHIP_PROGRAM_CONTROL, 8'h10);
    rdchk(ADDR_CHIP_PROGRAM_CONTROL, 8'h28);
    unlock();
    wb(1'h1, ADDR_CHIP_PROGRAM_CONTROL, 8'h54);
    rdchk(ADDR_CHIP_PROGRAM_CONTROL, 8'h38);
    chk("aux ram", {31'h0, o_aux_ram_enable}, 32'h1);
    // Stray key between the two halves must close access
    wb(1'h1, ADDR_PROGRAM_UNLOCK_KEY, UNLOCK_KEY_FIRST);
    wb(1'h1, ADDR_PROGRAM_UNLOCK_KEY, 8'h33);
    wb(1'h1, ADDR_PROGRAM_UNLOCK_KEY, UNLOCK_KEY_SECOND);
    wb(1'h1, ADDR_CHIP_PROGRAM_CONTROL, 8'h00);
    rdchk(ADDR_CHIP_PROGRAM_CONTROL, 8'h38);
    {i_p4_3, i_p2_7, i_p2_6} <= 3'h7;
    do_reset();
    unlock();
    wb(1'h1, ADDR_CHIP_PROGRAM_CONTROL, 8'h11);
    rdchk(ADDR_CHIP_PROGRAM_CONTROL, 8'h19);
    rdchk(ADDR_SECURITY, 8'hff);
    wb(1'h1, ADDR_SECURITY, 8'h7b);
    wb(1'h1, ADDR_SECURITY, 8'hff);
    rdchk(ADDR_SECURITY, 8'h7b);
    settle(2);
    chk("half gain", {31'h0, o_osc_half_gain}, 32'h1);
    chk("p0 encoded", {24'h0, o_p0_data}, 32'h66);
    {i_fetch_external, i_code_read_internal} <= 2'h3;
    settle(2);
    chk("read ok", {31'h0, o_code_read_internal_ok}, 32'h1);
    wb(1'h1, ADDR_SECURITY, 8'h79);
    settle(2);
    chk("read ok", {31'h0, o_code_read_internal_ok}, 32'h0);
    i_fetch_external <= 1'h0;
    settle(2);
    chk("read ok", {31'h0, o_code_read_internal_ok}, 32'h1);
    i_erase_all <= 1'h1;
    settle(2);
    i_erase_all <= 1'h0;
    rdchk(ADDR_SECURITY, 8'hff);
    settle(2);
    chk("half gain", {31'h0, o_osc_half_gain}, 32'h0);
    chk("p0 plain", {24'h0, o_p0_data}, 32'h3c);
    wb(1'h1, ADDR_SECURITY, 8'hfe);
    rdchk(ADDR_SECURITY, 8'h00);
    chk("access", {31'h0, o_code_access_allow}, 32'h0);
    i_erase_all <= 1'h1;
    settle(2);
    i_erase_all <= 1'h0;
    rdchk(8'hf0, 8'h00);
    unlock();
    wb(1'h1, ADDR_CHIP_PROGRAM_CONTROL, 8'h93);
    pulse_width(n);
    chk("reset width", n, CHIP_RESET_CYCLES);
    settle(4);
    rdchk(ADDR_CHIP_PROGRAM_CONTROL, 8'h08);
    wb(1'h1, ADDR_SOFT_TIMER, 8'h03);
    unlock();
    wb(1'h1, ADDR_CHIP_PROGRAM_CONTROL, SOFT_RESET_VALUE);
    chk("no early reset", {31'h0, o_chip_reset}, 32'h0);
    i_cpu_idle <= 1'h1;
    pulse_width(n);
    chk("soft reset width", n, CHIP_RESET_CYCLES);
    i_cpu_idle <= 1'h0;
    settle(4);
    chk("loader flag", {31'h0, o_loader_running_flag}, 32'h0);
    rdchk(ADDR_CHIP_PROGRAM_CONTROL, 8'h08);
    test_done();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    test_done();
  end
endmodule // boot_reset_security_ctrl_tb_top
`default_nettype wire
